// ### hw/mrt_pkg.sv
// package: constants for the mode-register two/three termination and refresh block
package mrt_pkg;
  // ---------------------------------------------------------------------------
  // register-port addresses (one per mode register, plus the status address)
  // ---------------------------------------------------------------------------
  localparam logic [3:0] MRT_ADDR_MODE_TWO = 4'h2;
  localparam logic [3:0] MRT_ADDR_MODE_THREE = 4'h3;
  localparam logic [3:0] MRT_ADDR_STAT = 4'h4;
  // ---------------------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------------------
  localparam int MRT_TWO_AUTO_BIT = 6;
  localparam int MRT_TWO_FORCED_BIT = 7;
  localparam int MRT_TWO_WRTERM_LO = 9;
  localparam int MRT_TWO_WRTERM_HI = 10;
  localparam int MRT_THREE_PATTERN_EN_BIT = 2;
  localparam logic [16:0] MRT_TWO_WMASK = 17'h006f8;
  localparam logic [16:0] MRT_THREE_WMASK = 17'h00007;
  // ---------------------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------------------
  localparam logic [16:0] MRT_TWO_RST = 17'h00000;
  localparam logic [16:0] MRT_THREE_RST = 17'h00000;
  // ---------------------------------------------------------------------------
  // termination select codes and refresh rate
  // ---------------------------------------------------------------------------
  localparam logic [2:0] MRT_NOM_OFF = 3'h0;
  localparam logic [1:0] MRT_WR_OFF = 2'h0;
  localparam logic [1:0] MRT_RATE_1X = 2'h1;
  localparam logic [1:0] MRT_RATE_2X = 2'h2;
  localparam logic [7:0] MRT_TEMP_LIMIT = 8'h55; // 85 degrees
  localparam logic [7:0] MRT_TEMP_MARGIN = 8'h03; // early switch allowed
  // ---------------------------------------------------------------------------
  // self-refresh period counts (1x rate base, 7.8 us at 40 MHz)
  // ---------------------------------------------------------------------------
  localparam int MRT_REF_PERIOD_NS = 7800;
  localparam int MRT_CLK_NS = 25;
  localparam int MRT_REF_CYC = MRT_REF_PERIOD_NS / MRT_CLK_NS;
  typedef enum logic [1:0] {
    MRT_TERM_NOM = 2'b00,
    MRT_TERM_WR = 2'b01,
    MRT_TERM_HIZ = 2'b10
  } mrt_term_t;
endpackage : mrt_pkg

// ### hw/mrt_refresh_timer.sv
// file: self-refresh pulse generator at the 1x or 2x rate
`timescale 1ns/100ps
`default_nettype none
module mrt_refresh_timer #(
  parameter int PERIOD = mrt_pkg::MRT_REF_CYC
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic enable,
  input wire logic double_rate,
  output logic tick
);
  logic [15:0] cnt_ff;
  logic [15:0] limit;
  // 2x rate halves the period; counter restarts whenever refresh is off
  assign limit = double_rate ? 16'(PERIOD / 2 - 1) : 16'(PERIOD - 1);
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_ff <= 16'h0000;
      tick <= 1'b0;
    end else if (!enable) begin
      cnt_ff <= 16'h0000;
      tick <= 1'b0;
    end else if (cnt_ff >= limit) begin
      cnt_ff <= 16'h0000;
      tick <= 1'b1;
    end else begin
      cnt_ff <= cnt_ff + 16'h0001;
      tick <= 1'b0;
    end
  end
endmodule : mrt_refresh_timer
`default_nettype wire

// ### hw/mrt_mode_regs.sv
// file: mode registers two and three with refresh rate and dynamic termination
//
// The register offsets and the plain strobed port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - mode register two bit 6 enables automatic temperature-tracked refresh rate
// - automatic tracking and forced double rate both off give the single 1x self-refresh rate
// - automatic tracking on switches to 2x above 85 degrees
// - automatic tracking may switch early, below 85 degrees, without data loss
// - mode register two bit 7 enables forced double refresh rate
// - forced double rate always refreshes at 2x
// - bits 10:9 select write termination; nonzero enables dynamic termination
// - termination changes on the fly without another mode-set
// - write termination during a write burst, nominal after it ends
// - nominal termination disabled gives high impedance
// - dynamic termination only in writes, independent of nominal setting
// - no dynamic termination during write leveling
// - mode register three holds contents until rewritten
// - rewriting mode register three leaves array contents untouched
// - mode register three holds calibration pattern register controls
module mrt_mode_regs #(
  parameter int REF_PERIOD = mrt_pkg::MRT_REF_CYC
) (
  input wire logic clk,
  input wire logic rst_b,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [16:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [16:0] reg_rdata,
  // device state inputs (asynchronous to clk)
  input wire logic [7:0] case_temp,
  input wire logic self_refresh_req,
  input wire logic write_burst,
  input wire logic write_leveling,
  input wire logic [2:0] nominal_termination_value,
  // outputs
  output logic [1:0] term_sel,
  output logic [2:0] term_value,
  output logic refresh_tick,
  output logic refresh_double,
  output logic calibration_pattern_register_en,
  output logic [1:0] calibration_pattern_sel,
  output logic option_conflict
);
  // ---------------------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------------------
  logic [7:0] temp_s1_ff;
  logic [7:0] temp_s2_ff;
  logic [2:0] ctl_s1_ff;
  logic [2:0] ctl_s2_ff;
  logic [2:0] nom_s1_ff;
  logic [2:0] nom_s2_ff;
  logic [7:0] temp_s3_ff;
  logic [7:0] temp_q_ff;
  logic [2:0] nom_s3_ff;
  logic [2:0] nom_q_ff;
  logic sref_s;
  logic wburst_s;
  logic wlevel_s;
  // first stage feeds only the second; pins are asynchronous to clk
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      temp_s1_ff <= 8'h00;
      temp_s2_ff <= 8'h00;
      ctl_s1_ff <= 3'h0;
      ctl_s2_ff <= 3'h0;
      nom_s1_ff <= 3'h0;
      nom_s2_ff <= 3'h0;
    end else begin
      temp_s1_ff <= case_temp;
      temp_s2_ff <= temp_s1_ff;
      ctl_s1_ff <= {write_leveling, write_burst, self_refresh_req};
      ctl_s2_ff <= ctl_s1_ff;
      nom_s1_ff <= nominal_termination_value;
      nom_s2_ff <= nom_s1_ff;
    end
  end
  assign sref_s = ctl_s2_ff[0];
  assign wburst_s = ctl_s2_ff[1];
  assign wlevel_s = ctl_s2_ff[2];
  // a multi-bit word is taken only once two samples agree, so a word caught
  // mid-change on the pins never reaches the decode; costs two more cycles
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      temp_s3_ff <= 8'h00;
      temp_q_ff <= 8'h00;
      nom_s3_ff <= 3'h0;
      nom_q_ff <= 3'h0;
    end else begin
      temp_s3_ff <= temp_s2_ff;
      nom_s3_ff <= nom_s2_ff;
      if (temp_s2_ff == temp_s3_ff) begin
        temp_q_ff <= temp_s2_ff;
      end
      if (nom_s2_ff == nom_s3_ff) begin
        nom_q_ff <= nom_s2_ff;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // mode registers
  // ---------------------------------------------------------------------------
  logic [16:0] mode_register_two_ff;
  logic [16:0] mode_register_three_ff;
  // reserved bits are masked; the controller is expected to write them zero
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_register_two_ff <= mrt_pkg::MRT_TWO_RST;
    end else if (reg_wr && reg_addr == mrt_pkg::MRT_ADDR_MODE_TWO) begin
      mode_register_two_ff <= reg_wdata & mrt_pkg::MRT_TWO_WMASK;
    end
  end
  // held until the next write; no path touches array state
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_register_three_ff <= mrt_pkg::MRT_THREE_RST;
    end else if (reg_wr && reg_addr == mrt_pkg::MRT_ADDR_MODE_THREE) begin
      mode_register_three_ff <= reg_wdata & mrt_pkg::MRT_THREE_WMASK;
    end
  end

  // ---------------------------------------------------------------------------
  // decoded fields
  // ---------------------------------------------------------------------------
  logic auto_temp_refresh_rate;
  logic forced_double_refresh_rate;
  logic [1:0] write_termination_value;
  logic dyn_term_en;
  assign auto_temp_refresh_rate =
    mode_register_two_ff[mrt_pkg::MRT_TWO_AUTO_BIT];
  assign forced_double_refresh_rate =
    mode_register_two_ff[mrt_pkg::MRT_TWO_FORCED_BIT];
  assign write_termination_value = mode_register_two_ff[
    mrt_pkg::MRT_TWO_WRTERM_HI:mrt_pkg::MRT_TWO_WRTERM_LO];
  assign dyn_term_en = write_termination_value != mrt_pkg::MRT_WR_OFF;
  // illegal combination is flagged, forced option then takes precedence
  assign option_conflict =
    auto_temp_refresh_rate && forced_double_refresh_rate;

  // ---------------------------------------------------------------------------
  // calibration pattern register controls
  // ---------------------------------------------------------------------------
  assign calibration_pattern_register_en =
    mode_register_three_ff[mrt_pkg::MRT_THREE_PATTERN_EN_BIT];
  assign calibration_pattern_sel = mode_register_three_ff[1:0];

  // ---------------------------------------------------------------------------
  // self-refresh rate selection
  // ---------------------------------------------------------------------------
  logic hot;
  logic nxt_double;
  logic double_ff;
  // switch a little early so the 2x rate is in place before 85 degrees
  assign hot = temp_q_ff >
    (mrt_pkg::MRT_TEMP_LIMIT - mrt_pkg::MRT_TEMP_MARGIN);
  always_comb begin
    if (forced_double_refresh_rate) begin
      nxt_double = 1'b1;
    end else if (auto_temp_refresh_rate) begin
      nxt_double = hot;
    end else begin
      nxt_double = 1'b0;
    end
  end
  // rate only changes between ticks via the timer's own limit compare
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      double_ff <= 1'b0;
    end else begin
      double_ff <= nxt_double;
    end
  end
  assign refresh_double = double_ff;

  mrt_refresh_timer #(
    .PERIOD(REF_PERIOD)
  ) u_timer (
    .clk(clk),
    .rst_b(rst_b),
    .enable(sref_s),
    .double_rate(double_ff),
    .tick(refresh_tick)
  );

  // ---------------------------------------------------------------------------
  // termination selection
  // ---------------------------------------------------------------------------
  logic nom_off;
  mrt_pkg::mrt_term_t nxt_term;
  mrt_pkg::mrt_term_t term_ff;
  logic [2:0] term_value_ff;
  assign nom_off = nom_q_ff == mrt_pkg::MRT_NOM_OFF;
  // dynamic switch is independent of nominal setting, blocked when leveling
  always_comb begin
    if (dyn_term_en && wburst_s && !wlevel_s) begin
      nxt_term = mrt_pkg::MRT_TERM_WR;
    end else if (nom_off) begin
      nxt_term = mrt_pkg::MRT_TERM_HIZ;
    end else begin
      nxt_term = mrt_pkg::MRT_TERM_NOM;
    end
  end
  // registered so term_sel and term_value always agree cycle by cycle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      term_ff <= mrt_pkg::MRT_TERM_HIZ;
      term_value_ff <= 3'h0;
    end else begin
      term_ff <= nxt_term;
      unique case (nxt_term)
        mrt_pkg::MRT_TERM_WR: term_value_ff <= {1'b0, write_termination_value};
        mrt_pkg::MRT_TERM_NOM: term_value_ff <= nom_q_ff;
        default: term_value_ff <= 3'h0;
      endcase
    end
  end
  assign term_sel = term_ff;
  assign term_value = term_value_ff;

  // ---------------------------------------------------------------------------
  // register read port: data one cycle after the strobe
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 17'h00000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        mrt_pkg::MRT_ADDR_MODE_TWO: reg_rdata <= mode_register_two_ff;
        mrt_pkg::MRT_ADDR_MODE_THREE: reg_rdata <= mode_register_three_ff;
        mrt_pkg::MRT_ADDR_STAT: reg_rdata <= {12'h000, option_conflict,
          wlevel_s, double_ff, term_ff};
        default: reg_rdata <= 17'h00000;
      endcase
    end else begin
      reg_rdata <= 17'h00000;
    end
  end

  // ---------------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------------
  property p_forced_double;
    @(posedge clk) disable iff (!rst_b)
    forced_double_refresh_rate |=> refresh_double;
  endproperty
  a_forced_double: assert property (p_forced_double)
    else $error("forced option did not give 2x rate");
  property p_single_rate;
    @(posedge clk) disable iff (!rst_b)
    (!forced_double_refresh_rate && !auto_temp_refresh_rate)
      |=> !refresh_double;
  endproperty
  a_single_rate: assert property (p_single_rate)
    else $error("2x rate with both options off");
  property p_auto_hot;
    @(posedge clk) disable iff (!rst_b)
    (auto_temp_refresh_rate && temp_q_ff > mrt_pkg::MRT_TEMP_LIMIT)
      |=> refresh_double;
  endproperty
  a_auto_hot: assert property (p_auto_hot)
    else $error("auto tracking stayed 1x above limit");
  property p_wr_term;
    @(posedge clk) disable iff (!rst_b)
    (dyn_term_en && wburst_s && !wlevel_s)
      |=> term_sel == mrt_pkg::MRT_TERM_WR;
  endproperty
  a_wr_term: assert property (p_wr_term)
    else $error("write termination not applied in burst");
  property p_no_wr_term_idle;
    @(posedge clk) disable iff (!rst_b)
    !wburst_s |=> term_sel != mrt_pkg::MRT_TERM_WR;
  endproperty
  a_no_wr_term_idle: assert property (p_no_wr_term_idle)
    else $error("write termination outside a write");
  property p_leveling;
    @(posedge clk) disable iff (!rst_b)
    wlevel_s |=> term_sel != mrt_pkg::MRT_TERM_WR;
  endproperty
  a_leveling: assert property (p_leveling)
    else $error("dynamic termination during leveling");
  property p_hiz;
    @(posedge clk) disable iff (!rst_b)
    (nom_off && !(dyn_term_en && wburst_s && !wlevel_s))
      |=> term_sel == mrt_pkg::MRT_TERM_HIZ && term_value == 3'h0;
  endproperty
  a_hiz: assert property (p_hiz)
    else $error("nominal off did not give high impedance");
  property p_mr3_hold;
    @(posedge clk) disable iff (!rst_b)
    !(reg_wr && reg_addr == mrt_pkg::MRT_ADDR_MODE_THREE)
      |=> $stable(mode_register_three_ff);
  endproperty
  a_mr3_hold: assert property (p_mr3_hold)
    else $error("register three changed without a write");
  property p_dyn_enable;
    @(posedge clk) disable iff (!rst_b)
    (write_termination_value == mrt_pkg::MRT_WR_OFF)
      |=> term_sel != mrt_pkg::MRT_TERM_WR;
  endproperty
  a_dyn_enable: assert property (p_dyn_enable)
    else $error("write termination with zero select");
  property p_auto_cold;
    @(posedge clk) disable iff (!rst_b)
    (auto_temp_refresh_rate && !forced_double_refresh_rate &&
      temp_q_ff <= (mrt_pkg::MRT_TEMP_LIMIT - mrt_pkg::MRT_TEMP_MARGIN))
      |=> !refresh_double;
  endproperty
  a_auto_cold: assert property (p_auto_cold)
    else $error("auto tracking went 2x while cool");
  property p_wr_value;
    @(posedge clk) disable iff (!rst_b)
    (dyn_term_en && wburst_s && !wlevel_s)
      |=> term_value == {1'b0, $past(write_termination_value)};
  endproperty
  a_wr_value: assert property (p_wr_value)
    else $error("write termination code not applied");
  property p_nom_value;
    @(posedge clk) disable iff (!rst_b)
    (!nom_off && !(dyn_term_en && wburst_s && !wlevel_s))
      |=> term_sel == mrt_pkg::MRT_TERM_NOM &&
        term_value == $past(nom_q_ff);
  endproperty
  a_nom_value: assert property (p_nom_value)
    else $error("nominal termination not restored");
  property p_two_hold;
    @(posedge clk) disable iff (!rst_b)
    !(reg_wr && reg_addr == mrt_pkg::MRT_ADDR_MODE_TWO)
      |=> $stable(mode_register_two_ff);
  endproperty
  a_two_hold: assert property (p_two_hold)
    else $error("register two changed without a write");
  property p_tick_pulse;
    @(posedge clk) disable iff (!rst_b)
    refresh_tick |=> !refresh_tick;
  endproperty
  a_tick_pulse: assert property (p_tick_pulse)
    else $error("refresh tick longer than one cycle");
  property p_no_tick_idle;
    @(posedge clk) disable iff (!rst_b)
    !sref_s |=> !refresh_tick;
  endproperty
  a_no_tick_idle: assert property (p_no_tick_idle)
    else $error("refresh tick outside self refresh");
  property p_two_reserved;
    @(posedge clk) disable iff (!rst_b)
    (mode_register_two_ff & ~mrt_pkg::MRT_TWO_WMASK) == 17'h00000;
  endproperty
  a_two_reserved: assert property (p_two_reserved)
    else $error("reserved register two bit stored");
endmodule : mrt_mode_regs
`default_nettype wire

// ### verification/mrt_ctrl_model.sv
// controller-side model: issues write bursts of four or eight
`timescale 1ns/100ps
`default_nettype none
module mrt_ctrl_model #(
  parameter int HOLD4 = 2,
  parameter int HOLD8 = 4
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic go,
  input wire logic eight,
  output logic write_burst,
  output logic busy
);
  int cnt;
  // burst held for its full length; a request mid-burst is ignored
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt <= 0;
      write_burst <= 1'b0;
    end else if (go && cnt == 0) begin
      cnt <= eight ? HOLD8 : HOLD4;
      write_burst <= 1'b1;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end else begin
      cnt <= 0;
      write_burst <= 1'b0;
    end
  end
  // mode-sets wait on this so they never overlap a burst
  assign busy = write_burst;
endmodule : mrt_ctrl_model
`default_nettype wire

// ### verification/tb_top.sv
// testbench: register port, refresh rate and dynamic termination
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  // ---------------------------------------------------------------
  // signals and design
  // ---------------------------------------------------------------
  logic clk, rst_b, reg_wr, reg_rd, sref, wlev, go, eight;
  logic [3:0] reg_addr;
  logic [16:0] reg_wdata, reg_rdata;
  logic [7:0] case_temp;
  logic [2:0] nom, term_value;
  logic [1:0] term_sel, cp_sel;
  logic tick, dbl, cp_en, conflict, write_burst, busy;
  int n_errors = 0;
  int total_checks = 0;
  int cyc = 0;
  localparam logic [3:0] A2 = mrt_pkg::MRT_ADDR_MODE_TWO;
  localparam logic [3:0] A3 = mrt_pkg::MRT_ADDR_MODE_THREE;
  // rate table: no row sets both options at once
  logic [16:0] r_mr2 [4] = '{17'h0, 17'h40, 17'h40, 17'h80};
  logic [7:0] r_tmp [4] = '{8'h64, 8'h1e, 8'h64, 8'h1e};
  logic r_dbl [4] = '{1'b0, 1'b0, 1'b1, 1'b1};
  int r_per [4] = '{8, 8, 4, 4};
  mrt_mode_regs #(.REF_PERIOD(8)) uut (.clk(clk), .rst_b(rst_b),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .case_temp(case_temp),
    .self_refresh_req(sref), .write_burst(write_burst),
    .write_leveling(wlev), .nominal_termination_value(nom),
    .term_sel(term_sel), .term_value(term_value), .refresh_tick(tick),
    .refresh_double(dbl), .calibration_pattern_register_en(cp_en),
    .calibration_pattern_sel(cp_sel), .option_conflict(conflict));
  mrt_ctrl_model ctl (.clk(clk), .rst_b(rst_b), .go(go), .eight(eight),
    .write_burst(write_burst), .busy(busy));
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [16:0] g, input logic [16:0] e,
                     input string m);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk
  task automatic chk_per(input int g, input int e, input string m);
    total_checks++;
    if (g != e) begin
      n_errors++;
      $display("[ERR] %0t %s got %0d exp %0d", $time, m, g, e);
    end
  endtask : chk_per
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wt
  task automatic wr(input logic [3:0] a, input logic [16:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  // read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [3:0] a, input logic [16:0] e,
                        input string m);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, e, m);
  endtask : rd_chk
  task automatic term_chk(input logic [1:0] s, input logic [2:0] v,
                          input string m);
    chk({12'h0, term_sel, term_value}, {12'h0, s, v}, m);
  endtask : term_chk
  // termination is looked at three edges after the burst starts
  task automatic burst_chk(input logic e, input logic [1:0] s,
                           input logic [2:0] v, input string m);
    @(posedge clk);
    eight <= e;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    wait (write_burst === 1'b1);
    wt(3);
    term_chk(s, v, m);
    wait (busy === 1'b0);
    wt(5);
  endtask : burst_chk
  // skips to a tick, then counts cycles to the next one
  task automatic per_chk(input int e, input string m);
    int n;
    n = 0;
    while (tick !== 1'b1 && n < 40) begin
      wt(1);
      n++;
    end
    n = 0;
    do begin
      wt(1);
      n++;
    end while (tick !== 1'b1 && n < 40);
    chk_per(n, e, m);
  endtask : per_chk
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : close_out
  // ---------------------------------------------------------------
  // clock, watchdog and sequence
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // a hang ends the run as a mismatch; real run is under 1000 cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_errors++;
      close_out();
    end
  end
  initial begin
    {rst_b, reg_wr, reg_rd, sref, wlev, go, eight} = 7'h0;
    reg_addr = 4'h0;
    reg_wdata = 17'h0;
    case_temp = 8'h1e;
    nom = 3'h0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    wt(3);
    term_chk(2'h2, 3'h0, "reset hi-z");
    rd_chk(A2, 17'h0, "reg two reset");
    rd_chk(A3, 17'h0, "reg three reset");
    rd_chk(4'h9, 17'h0, "unmapped");
    wr(A3, 17'h1ffff);
    rd_chk(A3, 17'h00007, "reg three mask");
    chk({14'h0, cp_en, cp_sel}, 17'h7, "pattern ctl");
    wr(A2, 17'h1ffff);
    rd_chk(A2, 17'h006f8, "reg two mask");
    wt(3);
    chk({15'h0, conflict, dbl}, 17'h3, "both set");
    rd_chk(mrt_pkg::MRT_ADDR_STAT, 17'h00016, "status");
    wr(A2, 17'h0);
    rd_chk(A3, 17'h00007, "reg three kept");
    wr(A3, 17'h0);
    wt(2);
    chk({14'h0, cp_en, cp_sel}, 17'h0, "pattern off");
    $display("test registers done");
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      sref <= 1'b0;
      case_temp <= r_tmp[i];
      wr(A2, r_mr2[i]);
      wt(5);
      chk({16'h0, dbl}, {16'h0, r_dbl[i]}, "rate");
      @(posedge clk);
      sref <= 1'b1;
      per_chk(r_per[i], "period");
    end
    @(posedge clk);
    sref <= 1'b0;
    nom <= 3'h3;
    $display("test refresh done");
    for (int c = 1; c < 4; c++) begin
      wr(A2, {6'h0, c[1:0], 9'h0});
      wt(5);
      term_chk(2'h0, 3'h3, "nominal idle");
      burst_chk(c[0], 2'h1, {1'b0, c[1:0]}, "write term");
      term_chk(2'h0, 3'h3, "nominal after");
    end
    @(posedge clk);
    wlev <= 1'b1;
    burst_chk(1'b1, 2'h0, 3'h3, "leveling");
    @(posedge clk);
    wlev <= 1'b0;
    wr(A2, 17'h0);
    burst_chk(1'b1, 2'h0, 3'h3, "no dynamic");
    wr(A2, 17'h00400);
    @(posedge clk);
    nom <= 3'h0;
    wt(5);
    term_chk(2'h2, 3'h0, "nominal off");
    burst_chk(1'b0, 2'h1, 3'h2, "dyn, nom off");
    term_chk(2'h2, 3'h0, "hi-z after");
    $display("test termination done");
    close_out();
  end
endmodule : tb_top
`default_nettype wire
